// File: logic/zar_zone_ctrl.v
`timescale 1ns/100ps
`include "zar_consts.vh"

// How it works
// - accumulate bit set: arriving carton is held
// - arrival/departure counts differ while zone occupied
// - arrival loads current tracking words 1 and 2
// - new count releases, then holds next arrival
// - release waits latched while downstream full
// - clearing accumulate bit releases, stops holding
// - set words attach only on count release
// - downstream zone is an identical copy
// - single-zone mode: one sensor, one or two rollers
// - singulation release default; arrival jam stays enabled
// - after discharge, hold arrivals until confirmation
module zar_zone_ctrl #(
  parameter NZ = 2,
  parameter FILT_CYCLES = 4,
  parameter JAM_CYCLES = 4000
) (
  input wire core_clk,
  input wire reset_n,
  input wire [`ZAR_ADDR_W-1:0] reg_addr,
  input wire [`ZAR_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`ZAR_DATA_W-1:0] reg_rdata,
  output wire irq,
  input wire [NZ-1:0] zone_sensor,
  input wire [NZ-1:0] downstream_full,
  input wire [NZ-1:0] next_arrival_ack,
  input wire [NZ*32-1:0] trk_in,
  output wire [NZ-1:0] roller_run,
  output reg [NZ-1:0] arrival_ack_out,
  output reg [NZ*32-1:0] trk_out
);

  localparam DW = `ZAR_DATA_W;
  localparam NEV = NZ * `ZAR_EV_PER_ZONE;
  localparam [15:0] JAM_LIMIT = JAM_CYCLES[15:0];

  // ----------------------------------------
  // global configuration, status and mask
  // ----------------------------------------
  reg [2:0] cfg_q;
  reg [NEV-1:0] status_q;
  reg [NEV-1:0] mask_q;
  wire [NEV-1:0] ev_set;
  wire single_zone = cfg_q[`ZAR_CFG_SINGLE];
  wire train_mode = cfg_q[`ZAR_CFG_TRAIN];
  wire jam_en = cfg_q[`ZAR_CFG_JAM_EN];

  // global decodes; the per-zone registers live in the low address window
  wire wr_cfg = reg_wr && (reg_addr == `ZAR_ADDR_CFG);
  wire wr_mask = reg_wr && (reg_addr == `ZAR_ADDR_MASK);
  wire rd_status = reg_rd && (reg_addr == `ZAR_ADDR_STATUS);
  wire zone_space = (reg_addr[7:5] == `ZAR_ZONE_SPACE);

  // config and mask writes; jam detection defaults on for singulation
  always @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_q <= `ZAR_CFG_RESET;
      mask_q <= `ZAR_MASK_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_q <= reg_wdata[2:0];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[NEV-1:0];
      end
    end
  end

  // sticky status; a new event in the clearing read cycle survives
  always @(posedge core_clk) begin
    if (!reset_n) begin
      status_q <= {NEV{1'b0}};
    end else if (rd_status) begin
      status_q <= ev_set;
    end else begin
      status_q <= status_q | ev_set;
    end
  end

  // level output: drops only when software reads status or masks the bit
  assign irq = |(status_q & mask_q);

  // ----------------------------------------
  // per-zone state, flattened for the read mux
  // ----------------------------------------
  wire [NZ-1:0] sens;
  wire [NZ*DW-1:0] ctrl_f;
  wire [NZ*DW-1:0] arr_f;
  wire [NZ*DW-1:0] dep_f;
  wire [NZ*32-1:0] cur_f;
  wire [NZ*32-1:0] set_f;
  wire [NZ*DW-1:0] rel_f;
  wire [NZ-1:0] zone_run;

  genvar z;
  generate
    for (z = 0; z < NZ; z = z + 1) begin : g_zone
      reg accum_q;
      reg accum_prev_q;
      reg sens_q;
      reg [DW-1:0] arr_cnt_q;
      reg [DW-1:0] dep_cnt_q;
      reg [31:0] cur_trk_q;
      reg [31:0] set_trk_q;
      reg set_dirty_q;
      reg [DW-1:0] rel_cnt_q;
      reg rel_pend_q;
      reg acc_next_q;
      reg hold_q;
      reg wait_ack_q;
      reg [15:0] jam_cnt_q;
      wire zsel;
      wire active;
      wire arrive;
      wire depart;
      wire ds_full;
      wire do_rel;
      wire cancel;
      wire wr_rel;
      wire jam_hit;

      zar_sensor_filter #(
        .FILT_CYCLES(FILT_CYCLES)
      ) u_filt (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sensor_raw(zone_sensor[z]),
        .sensor_clean(sens[z])
      );

      // second zone sleeps when the module is one long zone
      assign active = (z == 0) || !single_zone;
      assign zsel = zone_space && (reg_addr[4] == z);
      assign arrive = active && sens[z] && !sens_q;
      assign depart = active && !sens[z] && sens_q;
      // single long zone discharges straight to the module's neighbour
      assign ds_full = (single_zone && (z == 0) && (NZ > 1)) ?
                       downstream_full[NZ-1] : downstream_full[z];
      assign cancel = accum_prev_q && !accum_q;
      assign wr_rel = reg_wr && zsel && (reg_addr[3:0] == `ZAR_OFF_REL_NEXT) &&
                      (reg_wdata != rel_cnt_q);
      assign do_rel = hold_q && rel_pend_q && !ds_full;
      assign jam_hit = wait_ack_q && jam_en && (jam_cnt_q == JAM_LIMIT);

      // accumulate control bit and its edge history
      always @(posedge core_clk) begin
        if (!reset_n) begin
          accum_q <= 1'b0;
          accum_prev_q <= 1'b0;
          sens_q <= 1'b0;
        end else begin
          accum_prev_q <= accum_q;
          sens_q <= sens[z];
          if (reg_wr && zsel && (reg_addr[3:0] == `ZAR_OFF_CTRL)) begin
            accum_q <= reg_wdata[`ZAR_CTRL_ACCUM];
          end
        end
      end

      // counters differ exactly while a carton blocks the eye
      always @(posedge core_clk) begin
        if (!reset_n) begin
          arr_cnt_q <= `ZAR_ZERO16;
          dep_cnt_q <= `ZAR_ZERO16;
        end else begin
          if (arrive) begin
            arr_cnt_q <= arr_cnt_q + 16'h0001;
          end
          if (depart) begin
            dep_cnt_q <= dep_cnt_q + 16'h0001;
          end
        end
      end

      // release handshake: count compare, latch, then hold next
      always @(posedge core_clk) begin
        if (!reset_n) begin
          rel_cnt_q <= `ZAR_ZERO16;
          rel_pend_q <= 1'b0;
          acc_next_q <= 1'b0;
          hold_q <= 1'b0;
        end else begin
          if (wr_rel) begin
            rel_cnt_q <= reg_wdata;
            rel_pend_q <= 1'b1;
          end else if (do_rel || cancel) begin
            rel_pend_q <= 1'b0;
          end
          if (cancel) begin
            hold_q <= 1'b0;
            acc_next_q <= 1'b0;
          end else if (do_rel) begin
            hold_q <= 1'b0;
            acc_next_q <= 1'b1;
          end else if (arrive && (accum_q || acc_next_q)) begin
            hold_q <= 1'b1;
            acc_next_q <= 1'b0;
          end
        end
      end

      // tracking: load on arrival, overwrite only by count release
      always @(posedge core_clk) begin
        if (!reset_n) begin
          cur_trk_q <= 32'h00000000;
          set_trk_q <= 32'h00000000;
          set_dirty_q <= 1'b0;
        end else begin
          if (reg_wr && zsel && (reg_addr[3:0] == `ZAR_OFF_SET_TRK1)) begin
            set_trk_q[15:0] <= reg_wdata;
          end
          if (reg_wr && zsel && (reg_addr[3:0] == `ZAR_OFF_SET_TRK2)) begin
            set_trk_q[31:16] <= reg_wdata;
          end
          if (reg_wr && zsel && ((reg_addr[3:0] == `ZAR_OFF_SET_TRK1) ||
              (reg_addr[3:0] == `ZAR_OFF_SET_TRK2))) begin
            set_dirty_q <= 1'b1;
          end else if (cancel) begin
            set_dirty_q <= 1'b0;
          end else if (do_rel) begin
            set_dirty_q <= 1'b0;
          end
          if (arrive) begin
            cur_trk_q <= trk_in[z*32 +: 32];
          end else if (do_rel && set_dirty_q) begin
            cur_trk_q <= set_trk_q;
          end
        end
      end

      // singulation: after discharge wait for the next zone's confirm
      always @(posedge core_clk) begin
        if (!reset_n) begin
          wait_ack_q <= 1'b0;
          jam_cnt_q <= `ZAR_ZERO16;
        end else begin
          if (depart && !train_mode) begin
            wait_ack_q <= 1'b1;
            jam_cnt_q <= `ZAR_ZERO16;
          end else if (next_arrival_ack[z] || jam_hit) begin
            wait_ack_q <= 1'b0;
            jam_cnt_q <= `ZAR_ZERO16;
          end else if (wait_ack_q && (jam_cnt_q != JAM_LIMIT)) begin
            jam_cnt_q <= jam_cnt_q + 16'h0001;
          end
        end
      end

      // roller runs unless holding, blocked, or a carton at the eye awaits confirmation
      assign zone_run[z] = active && !hold_q && !ds_full &&
                           !(sens[z] && wait_ack_q);

      // arrival confirm upstream and tracking passed downstream
      always @(posedge core_clk) begin
        if (!reset_n) begin
          arrival_ack_out[z] <= 1'b0;
          trk_out[z*32 +: 32] <= 32'h00000000;
        end else begin
          arrival_ack_out[z] <= arrive;
          if (depart) begin
            trk_out[z*32 +: 32] <= cur_trk_q;
          end
        end
      end

      assign ev_set[z*`ZAR_EV_PER_ZONE + `ZAR_EV_ARRIVE] = arrive;
      assign ev_set[z*`ZAR_EV_PER_ZONE + `ZAR_EV_DEPART] = depart;
      assign ev_set[z*`ZAR_EV_PER_ZONE + `ZAR_EV_RELEASE] = do_rel;
      assign ev_set[z*`ZAR_EV_PER_ZONE + `ZAR_EV_JAM] = jam_hit;

      assign ctrl_f[z*DW +: DW] = {{(DW-1){1'b0}}, accum_q};
      assign arr_f[z*DW +: DW] = arr_cnt_q;
      assign dep_f[z*DW +: DW] = dep_cnt_q;
      assign cur_f[z*32 +: 32] = cur_trk_q;
      assign set_f[z*32 +: 32] = set_trk_q;
      assign rel_f[z*DW +: DW] = rel_cnt_q;
    end
  endgenerate

  // ----------------------------------------
  // rollers: in one-zone mode both rollers follow zone 0
  // ----------------------------------------
  assign roller_run[0] = zone_run[0];
  generate
    for (z = 1; z < NZ; z = z + 1) begin : g_roll
      assign roller_run[z] = single_zone ? zone_run[0] : zone_run[z];
    end
  endgenerate

  // ----------------------------------------
  // read path: data stands the cycle after the strobe, else zero
  // ----------------------------------------
  reg [DW-1:0] rd_mux;
  reg [3:0] zi;

  // decode per-zone and global registers; unmapped reads zero
  always @* begin
    rd_mux = `ZAR_ZERO16;
    zi = {3'h0, reg_addr[4]};
    if (zone_space && (zi < NZ)) begin
      case (reg_addr[3:0])
        `ZAR_OFF_CTRL: rd_mux = ctrl_f[zi*DW +: DW];
        `ZAR_OFF_ARR_CNT: rd_mux = arr_f[zi*DW +: DW];
        `ZAR_OFF_DEP_CNT: rd_mux = dep_f[zi*DW +: DW];
        `ZAR_OFF_CUR_TRK1: rd_mux = cur_f[zi*32 +: 16];
        `ZAR_OFF_CUR_TRK2: rd_mux = cur_f[zi*32+16 +: 16];
        `ZAR_OFF_SET_TRK1: rd_mux = set_f[zi*32 +: 16];
        `ZAR_OFF_SET_TRK2: rd_mux = set_f[zi*32+16 +: 16];
        `ZAR_OFF_REL_CNT: rd_mux = rel_f[zi*DW +: DW];
        `ZAR_OFF_REL_NEXT: rd_mux = rel_f[zi*DW +: DW];
        default: rd_mux = `ZAR_ZERO16;
      endcase
    end else if (reg_addr == `ZAR_ADDR_CFG) begin
      rd_mux = {{(DW-3){1'b0}}, cfg_q};
    end else if (reg_addr == `ZAR_ADDR_STATUS) begin
      rd_mux = {{(DW-NEV){1'b0}}, status_q};
    end else if (reg_addr == `ZAR_ADDR_MASK) begin
      rd_mux = {{(DW-NEV){1'b0}}, mask_q};
    end
  end

  // read data is valid only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= `ZAR_ZERO16;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= `ZAR_ZERO16;
    end
  end

endmodule

// File: common/zar_consts.vh
`ifndef ZAR_CONSTS_VH
`define ZAR_CONSTS_VH

// ----------------------------------------
// register bus geometry
// ----------------------------------------
`define ZAR_ADDR_W 8
`define ZAR_DATA_W 16

// ----------------------------------------
// per-zone window: addr[7:5]=0, addr[4]=zone, addr[3:0]=offset
// ----------------------------------------
`define ZAR_ZONE_SPACE 3'h0
`define ZAR_OFF_CTRL 4'h0
`define ZAR_OFF_ARR_CNT 4'h1
`define ZAR_OFF_DEP_CNT 4'h2
`define ZAR_OFF_CUR_TRK1 4'h3
`define ZAR_OFF_CUR_TRK2 4'h4
`define ZAR_OFF_SET_TRK1 4'h5
`define ZAR_OFF_SET_TRK2 4'h6
`define ZAR_OFF_REL_CNT 4'h7
`define ZAR_OFF_REL_NEXT 4'h8

// ----------------------------------------
// global registers
// ----------------------------------------
`define ZAR_ADDR_CFG 8'h20
`define ZAR_ADDR_STATUS 8'h21
`define ZAR_ADDR_MASK 8'h22

// ----------------------------------------
// field positions
// ----------------------------------------
`define ZAR_CTRL_ACCUM 0
`define ZAR_CFG_SINGLE 0
`define ZAR_CFG_TRAIN 1
`define ZAR_CFG_JAM_EN 2
// status bits per zone z: base + 4*z
`define ZAR_EV_ARRIVE 0
`define ZAR_EV_DEPART 1
`define ZAR_EV_RELEASE 2
`define ZAR_EV_JAM 3
`define ZAR_EV_PER_ZONE 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define ZAR_CFG_RESET 3'h4
`define ZAR_MASK_RESET 8'h00
`define ZAR_ZERO16 16'h0000

`endif

// File: logic/zar_sensor_filter.v
`timescale 1ns/100ps
`include "zar_consts.vh"

// ----------------------------------------
// photo-eye filter: output follows input only after it holds steady
// ----------------------------------------
module zar_sensor_filter #(
  parameter FILT_CYCLES = 4
) (
  input wire core_clk,
  input wire reset_n,
  input wire sensor_raw,
  output reg sensor_clean
);

  localparam CW = 8;
  localparam [CW-1:0] LIMIT = FILT_CYCLES[CW-1:0];

  reg [CW-1:0] cnt_q;
  reg sensor_q;

  // sample first so the comparator never sees a changing pin mid-cycle
  always @(posedge core_clk) begin
    if (!reset_n) begin
      sensor_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
      sensor_clean <= 1'b0;
    end else begin
      sensor_q <= sensor_raw;
      if (sensor_q == sensor_clean) begin
        cnt_q <= {CW{1'b0}};
      end else if (cnt_q == LIMIT) begin
        sensor_clean <= sensor_q;
        cnt_q <= {CW{1'b0}};
      end else begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

endmodule

// File: test/zar_next_sim.sv
`timescale 1ns/100ps
// ----------
// next module: confirms each carton that rolled off a zone
// ----------
module zar_next_sim #(
  parameter [3:0] DLY = 4'h6
) (
  input wire core_clk,
  input wire reset_n,
  input wire [1:0] eye,
  input wire [1:0] run,
  output reg [1:0] ack
);
  reg [1:0] eye_q;
  reg [3:0] cnt_q [0:1];
  integer i;
  // travel time after the eye clears, then a one-cycle confirm
  always @(posedge core_clk) begin
    eye_q <= eye;
    for (i = 0; i < 2; i = i + 1) begin
      ack[i] <= reset_n && cnt_q[i] == 4'h1;
      if (!reset_n) cnt_q[i] <= 4'h0;
      else if (eye_q[i] && !eye[i] && run[i]) cnt_q[i] <= DLY;
      else if (cnt_q[i] != 4'h0) cnt_q[i] <= cnt_q[i] - 4'h1;
    end
  end
endmodule

// File: test/zar_zone_ctrl_assertions.sv
`timescale 1ns/100ps
// ----------
// port checker of the zone controller
// ----------
module zar_zone_chk #(
  parameter NZ = 2
) (
  input wire core_clk,
  input wire reset_n,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire irq,
  input wire [NZ-1:0] zone_sensor,
  input wire [NZ-1:0] downstream_full,
  input wire [NZ-1:0] roller_run,
  input wire [NZ-1:0] arrival_ack_out,
  input wire [NZ*32-1:0] trk_out
);
  reg [7:0] mask_q;
  reg single_q;
  // shadow mask and zone layout; status itself is hidden, so only the off case is exact
  always @(posedge core_clk) begin
    if (!reset_n) begin
      mask_q <= 8'h00;
      single_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h22) mask_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == 8'h20) single_q <= reg_wdata[0];
    end
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // zone 1 cancelled, then four cycles of room downstream
  sequence s_cancel;
    !single_q && reg_wr && reg_addr == 8'h10 && !reg_wdata[0] ##1 (!downstream_full[1]) [*4];
  endsequence
  property p_cancel; s_cancel |-> roller_run[1]; endproperty
  // one long zone discharges to the module's last neighbour
  property p_full;
    (single_q ? downstream_full[NZ-1] : downstream_full[0]) |-> !roller_run[0];
  endproperty
  property p_single; single_q |-> roller_run[NZ-1] == roller_run[0]; endproperty
  property p_rd_idle; !reg_rd |=> reg_rdata == 16'h0000; endproperty
  property p_irq_off; mask_q == 8'h00 |-> !irq; endproperty
  property p_ack_pulse; arrival_ack_out[0] |=> !arrival_ack_out[0]; endproperty
  property p_ack0; arrival_ack_out[0] |-> $past(zone_sensor[0], 2); endproperty
  property p_ack1; arrival_ack_out[1] |-> $past(zone_sensor[1], 2); endproperty
  property p_trk; $changed(trk_out[31:0]) |-> !zone_sensor[0]; endproperty
  a_cancel: assert property (p_cancel) else $error("held after cancel");
  a_full: assert property (p_full) else $error("ran while full");
  a_rd_idle: assert property (p_rd_idle) else $error("read data lingers");
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
  a_ack0: assert property (p_ack0) else $error("ack without carton");
  a_ack1: assert property (p_ack1) else $error("ack without carton");
  a_trk: assert property (p_trk) else $error("tracking out early");
  a_single: assert property (p_single) else $error("rollers split in one zone");
endmodule
bind zar_zone_ctrl zar_zone_chk #(.NZ(NZ)) u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .zone_sensor(zone_sensor),
  .downstream_full(downstream_full), .roller_run(roller_run),
  .arrival_ack_out(arrival_ack_out), .trk_out(trk_out));

// File: test/zone_accumulate_release_control_bench.sv
`timescale 1ns/100ps
module zone_accumulate_release_control_bench;
  reg core_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg [7:0] reg_addr = 8'h00;
  reg [15:0] reg_wdata = 16'h0000, rv, cnt;
  reg [1:0] zone_sensor = 2'h0, downstream_full = 2'h0;
  reg [63:0] trk_in = 64'h0;
  wire [15:0] reg_rdata;
  wire irq;
  wire [1:0] roller_run, arrival_ack_out, next_ack;
  wire [63:0] trk_out;
  integer mismatches = 0, n_tests = 0;
  // short filter and jam counts keep the run brief
  zar_zone_ctrl #(.NZ(2), .FILT_CYCLES(1), .JAM_CYCLES(40)) u_dut (.core_clk(core_clk),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .zone_sensor(zone_sensor),
    .downstream_full(downstream_full), .next_arrival_ack(next_ack), .trk_in(trk_in),
    .roller_run(roller_run), .arrival_ack_out(arrival_ack_out), .trk_out(trk_out));
  zar_next_sim u_next (.core_clk(core_clk), .reset_n(reset_n), .eye(zone_sensor),
    .run(roller_run), .ack(next_ack));
  // 125 MHz
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // ----------
  // helpers
  // ----------
  task chk(input [63:0] got, input [63:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task arrive(input integer z, input [31:0] t);
    integer k;
    @(posedge core_clk);
    trk_in[z*32+:32] <= t;
    zone_sensor[z] <= 1'b1;
    for (k = 0; k < 30 && arrival_ack_out[z] !== 1'b1; k = k + 1) @(negedge core_clk);
    chk(arrival_ack_out[z], 1'b1);
  endtask
  task depart(input integer z);
    @(posedge core_clk);
    zone_sensor[z] <= 1'b0;
    repeat (12) @(negedge core_clk);
  endtask
  // hold, equal count ignored, release with new words
  task t_hold(input integer z);
    reg [7:0] b;
    b = 8'(z * 16);
    wr(b, 16'h0001);
    arrive(z, 32'h5a5a_0010 + z);
    rd(b + 8'h3);
    chk(rv, 16'h0010 + z);
    rd(b + 8'h4);
    chk(rv, 16'h5a5a);
    rd(b + 8'h1);
    cnt = rv;
    rd(b + 8'h2);
    chk(rv + 16'h1, cnt);
    rd(b + 8'h7);
    wr(b + 8'h8, rv);
    repeat (4) @(negedge core_clk);
    chk(roller_run[z], 1'b0);
    wr(b + 8'h5, 16'hc001);
    wr(b + 8'h6, 16'hc0de);
    wr(b + 8'h8, rv + 16'h1);
    repeat (4) @(negedge core_clk);
    chk(roller_run[z], 1'b1);
    depart(z);
    chk(trk_out[z*32+:32], 32'hc0de_c001);
    rd(b + 8'h2);
    chk(rv, cnt);
    $display("hold zone %0d done", z);
  endtask
  // release written while downstream is full
  task t_full;
    arrive(0, 32'h0000_4321);
    repeat (4) @(negedge core_clk);
    chk(roller_run[0], 1'b0);
    @(posedge core_clk);
    downstream_full[0] <= 1'b1;
    rd(8'h07);
    wr(8'h08, rv + 16'h1);
    rd(8'h07);
    chk(rv, 16'h0002);
    repeat (10) @(negedge core_clk);
    chk(roller_run[0], 1'b0);
    @(posedge core_clk);
    downstream_full[0] <= 1'b0;
    repeat (4) @(negedge core_clk);
    chk(roller_run[0], 1'b1);
    depart(0);
    $display("deferred release done");
  endtask
  // cancel drops written words and stops holding
  task t_cancel;
    arrive(1, 32'h0bad_f00d);
    repeat (4) @(negedge core_clk);
    chk(roller_run[1], 1'b0);
    wr(8'h15, 16'h1111);
    wr(8'h16, 16'h2222);
    wr(8'h10, 16'h0000);
    repeat (4) @(negedge core_clk);
    chk(roller_run[1], 1'b1);
    depart(1);
    chk(trk_out[63:32], 32'h0bad_f00d);
    arrive(1, 32'h0000_0077);
    repeat (4) @(negedge core_clk);
    chk(roller_run[1], 1'b1);
    depart(1);
    $display("cancel done");
  endtask
  // config default, unmapped read, sticky status and mask
  task t_irq;
    rd(8'h20);
    chk(rv, 16'h0004);
    rd(8'h30);
    chk(rv, 16'h0000);
    rd(8'h21);
    wr(8'h22, 16'h0010);
    @(negedge core_clk);
    chk(irq, 1'b0);
    arrive(1, 32'h0000_0099);
    @(negedge core_clk);
    chk(irq, 1'b1);
    rd(8'h21);
    chk(rv[4], 1'b1);
    @(negedge core_clk);
    chk(irq, 1'b0);
    depart(1);
    $display("status and mask done");
  endtask
  // confirm withheld: singulation waits, then times out; train mode never waits
  task t_jam(input [15:0] cfgv, input w);
    wr(8'h20, cfgv);
    wr(8'h00, 16'h0000);
    @(posedge core_clk);
    downstream_full[0] <= 1'b1;
    arrive(0, 32'h0000_0a00);
    depart(0);
    @(posedge core_clk);
    downstream_full[0] <= 1'b0;
    rd(8'h21);
    arrive(0, 32'h0000_0a01);
    chk(roller_run[0], !w);
    repeat (50) @(negedge core_clk);
    chk(roller_run[0], 1'b1);
    rd(8'h21);
    chk(rv[3], w);
    depart(0);
    $display("confirm wait cfg %h done", cfgv);
  endtask
  // one long zone: both rollers follow zone 0 and the last neighbour's full flag
  task t_single;
    wr(8'h20, 16'h0005);
    @(posedge core_clk);
    downstream_full <= 2'h2;
    @(negedge core_clk);
    chk(roller_run, 2'h0);
    @(posedge core_clk);
    downstream_full <= 2'h0;
    @(negedge core_clk);
    chk(roller_run, 2'h3);
    wr(8'h20, 16'h0004);
    $display("single zone done");
  endtask
  // main sequence after eight reset cycles
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_hold(0);
    t_hold(1);
    t_full;
    t_cancel;
    t_irq;
    t_jam(16'h0004, 1'b1);
    t_jam(16'h0006, 1'b0);
    t_single;
    close_out;
  end
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches = mismatches + 1;
    close_out;
  end
endmodule
